//--- core/acd_consts.vh
// Constants for the attenuation code decoder
`ifndef ACD_CONSTS_VH
`define ACD_CONSTS_VH
`define ACD_SEL_INPUT     8'h04
`define ACD_SEL_VOLUME    8'h20
`define ACD_SEL_FADER_FL  8'h28
`define ACD_SEL_FADER_FR  8'h29
`define ACD_SEL_FADER_RL  8'h2a
`define ACD_SEL_FADER_RR  8'h2b
`define ACD_STEP_MSB      5
`define ACD_STEP_INF      6'h3f
`define ACD_VOL_MAX_STEP  6'h28
`define ACD_ATT_RESET     8'hbf
`define ACD_SEL_SHUNT     3'h5
`define ACD_SEL_RESET     3'h0
`endif

//--- core/acd_sync.v
// Two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none
module acd_sync #(
    parameter RESET_VALUE = 1'b1
) (
    // Clock and reset
    input  wire clk,
    input  wire rst,
    // Pin and synchronised level
    input  wire pin,
    output reg  level
);
    reg stage1;

    always @(posedge clk) begin
        if (rst) begin
            stage1 <= RESET_VALUE;
            level  <= RESET_VALUE;
        end else begin
            stage1 <= pin;
            level  <= stage1;
        end
    end
endmodule // acd_sync
`default_nettype wire

//--- core/acd_decoder.v
// Attenuation code decoder with forced mute and input shunt control
// What this block does
// - Each attenuation byte carries one in bit 7, zero in bit 6 and a step count n in bits 5..0 meaning -n dB, with all ones meaning infinite attenuation.
// - The main volume takes only step counts 0 to 40, and larger counts are legal only for the faders.
// - A low level on the forced-mute pin mutes all outputs regardless of registers.
// - A high level on the forced-mute pin leaves muting to the register settings alone.
// - The shunt selector code closes the input shunt switch for all inputs together.
// - Any other selector code keeps the input shunt switch open.
// - A volume step count above 40 is applied as 40 dB.
// - The volume byte sits at select address 20 hex and the faders at 28 to 2b hex.
`timescale 1ns/100ps
`default_nettype none
`include "acd_consts.vh"
module acd_decoder (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Byte write from the serial bus engine
    input  wire       wr_ack,
    input  wire [7:0] wr_sel,
    input  wire [7:0] wr_data,
    // Forced-mute pin, active low
    input  wire       mute_n,
    // Register mute request
    input  wire       reg_mute,
    // Decoded attenuation steps
    output reg  [5:0] volume_step,
    output reg  [5:0] front_left_step,
    output reg  [5:0] front_right_step,
    output reg  [5:0] rear_left_step,
    output reg  [5:0] rear_right_step,
    // Infinite attenuation flags per fader
    output reg  [3:0] fader_inf,
    // Output mute and shunt switch
    output reg        output_mute,
    output reg        input_shunt_switch,
    // Last volume or fader byte held malformed marker bits
    output reg        format_error
);
    wire      mute_pin_level;
    reg [7:0] main_volume_attenuation;
    reg [7:0] output_fader_attenuation [0:3];
    reg [2:0] input_selector;
    integer   i;
    integer   j;

    function [5:0] vol_clamp;
        input [5:0] n;
        begin
            if (n > `ACD_VOL_MAX_STEP)
                vol_clamp = `ACD_VOL_MAX_STEP;
            else
                vol_clamp = n;
        end
    endfunction

    function marker_ok;
        input [7:0] b;
        begin
            marker_ok = (b[7:6] == 2'b10);
        end
    endfunction

    acd_sync #(.RESET_VALUE(1'b1)) u_mute_sync (
        .clk   (clk),
        .rst   (rst),
        .pin   (mute_n),
        .level (mute_pin_level)
    );

    // Store bytes only on acknowledged writes
    always @(posedge clk) begin
        if (rst) begin
            main_volume_attenuation <= `ACD_ATT_RESET;
            for (i = 0; i < 4; i = i + 1)
                output_fader_attenuation[i] <= `ACD_ATT_RESET;
            input_selector <= `ACD_SEL_RESET;
            format_error   <= 1'b0;
        end else if (wr_ack) begin
            case (wr_sel)
                `ACD_SEL_VOLUME: begin
                    main_volume_attenuation <= wr_data;
                    format_error <= ~marker_ok(wr_data);
                end
                `ACD_SEL_FADER_FL, `ACD_SEL_FADER_FR,
                `ACD_SEL_FADER_RL, `ACD_SEL_FADER_RR: begin
                    output_fader_attenuation[wr_sel[1:0]] <= wr_data;
                    format_error <= ~marker_ok(wr_data);
                end
                `ACD_SEL_INPUT: input_selector <= wr_data[2:0];
                default: ;
            endcase
        end
    end

    // Decoded outputs, all registered
    always @(posedge clk) begin
        if (rst) begin
            volume_step        <= `ACD_VOL_MAX_STEP;
            front_left_step    <= `ACD_STEP_INF;
            front_right_step   <= `ACD_STEP_INF;
            rear_left_step     <= `ACD_STEP_INF;
            rear_right_step    <= `ACD_STEP_INF;
            fader_inf          <= 4'hf;
            output_mute        <= 1'b1;
            input_shunt_switch <= 1'b0;
        end else begin
            volume_step      <= vol_clamp(main_volume_attenuation[`ACD_STEP_MSB:0]);
            front_left_step  <= output_fader_attenuation[0][`ACD_STEP_MSB:0];
            front_right_step <= output_fader_attenuation[1][`ACD_STEP_MSB:0];
            rear_left_step   <= output_fader_attenuation[2][`ACD_STEP_MSB:0];
            rear_right_step  <= output_fader_attenuation[3][`ACD_STEP_MSB:0];
            for (j = 0; j < 4; j = j + 1)
                fader_inf[j] <= (output_fader_attenuation[j][`ACD_STEP_MSB:0]
                                 == `ACD_STEP_INF);
            output_mute <= ~mute_pin_level | reg_mute;
            input_shunt_switch <= (input_selector == `ACD_SEL_SHUNT);
        end
    end
endmodule // acd_decoder
`default_nettype wire

//--- dv/acd_host.sv
// Host model writing bytes
`timescale 1ns/100ps
`default_nettype none
module acd_host (
    input  wire logic       clk,
    output var  logic       wr_ack = 0,
    output var  logic [7:0] wr_sel = 0,
    output var  logic [7:0] wr_data = 0
);
    // Acknowledged write for one cycle, then ack drops with select and data inverted
    task automatic wr(input logic [7:0] s, d);
        @(posedge clk);
        {wr_ack, wr_sel, wr_data} <= {1'b1, s, d};
        @(posedge clk);
        {wr_ack, wr_sel, wr_data} <= {1'b0, ~s, ~d};
    endtask
endmodule // acd_host
`default_nettype wire

//--- dv/acd_decoder_asserts.sv
// Port assertions
`timescale 1ns/100ps
`default_nettype none
module acd_chk (
    input wire logic       clk, rst, wr_ack, mute_n, reg_mute, output_mute, input_shunt_switch,
    input wire logic [7:0] wr_sel, wr_data,
    input wire logic [5:0] volume_step, front_left_step, rear_right_step
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence vw; wr_ack && wr_sel == 8'h20; endsequence
    AST_VOL: assert property (vw |-> ##3 volume_step ==
        ($past(wr_data[5:0], 3) > 6'h28 ? 6'h28 : $past(wr_data[5:0], 3))) else $error("vol");
    AST_FL: assert property (wr_ack && wr_sel == 8'h28 |-> ##3
        front_left_step == $past(wr_data[5:0], 3)) else $error("fl");
    AST_RR: assert property (wr_ack && wr_sel == 8'h2b |-> ##3
        rear_right_step == $past(wr_data[5:0], 3)) else $error("rr");
    AST_PIN: assert property (!mute_n |-> ##3 output_mute) else $error("pin");
    AST_FREE: assert property ((mute_n && !reg_mute) [*4] |=> !output_mute) else $error("free");
    AST_REG: assert property (reg_mute [*2] |=> output_mute) else $error("reg");
    AST_SH: assert property (wr_ack && wr_sel == 8'h04 |-> ##3
        input_shunt_switch == ($past(wr_data[2:0], 3) == 3'h5)) else $error("shunt");
    AST_HOLD: assert property (!wr_ack [*2] |=> $stable(volume_step)) else $error("hold");
endmodule // acd_chk
bind acd_decoder acd_chk u_chk (.*);
`default_nettype wire

//--- dv/attenuation_code_decoder_tb_top.sv
// Decoder testbench
`timescale 1ns/100ps
`default_nettype none
module attenuation_code_decoder_tb_top;
    logic       clk = 0, rst = 1, mute_n = 1, reg_mute = 0;
    wire        ack, mute, sh, ferr;
    wire  [7:0] sel, dat;
    wire  [5:0] vol, fs [4];
    wire  [3:0] inf;
    int         error_cnt = 0, total_checks = 0, cyc = 0;
    acd_host u_host (.clk(clk), .wr_ack(ack), .wr_sel(sel), .wr_data(dat));
    acd_decoder dut (.clk(clk), .rst(rst), .wr_ack(ack), .wr_sel(sel), .wr_data(dat),
        .mute_n(mute_n), .reg_mute(reg_mute), .volume_step(vol), .front_left_step(fs[0]),
        .front_right_step(fs[1]), .rear_left_step(fs[2]), .rear_right_step(fs[3]),
        .fader_inf(inf), .output_mute(mute), .input_shunt_switch(sh), .format_error(ferr));
    initial forever #50 clk = ~clk;
    task chk(input logic [5:0] g, e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, g, e);
        end
    endtask
    task w(input logic [7:0] s, d);
        u_host.wr(s, d);
        repeat (3) @(posedge clk);
    endtask
    task t_vol;
        logic [5:0] n [4] = '{6'h28, 6'h29, 6'h3f, 6'h00};
        w(8'h20, 8'h05);
        chk(vol, 6'h05);
        chk(ferr, 6'h01);
        foreach (n[i]) begin
            w(8'h20, {2'b10, n[i]});
            chk(vol, n[i] > 6'h28 ? 6'h28 : n[i]);
        end
        chk(ferr, 6'h00);
        w(8'h21, 8'hbf);
        chk(vol, 6'h00);
        $display("volume done");
    endtask
    task t_fad;
        logic [5:0] n [4] = '{6'h3f, 6'h3e, 6'h00, 6'h29};
        foreach (n[i]) u_host.wr(8'h28 + 8'(i), {2'b10, n[i]});
        repeat (3) @(posedge clk);
        foreach (n[i]) begin
            chk(fs[i], n[i]);
            chk(inf[i], n[i] == 6'h3f);
        end
        $display("fader done");
    endtask
    task t_mute;
        mute_n <= 0;
        repeat (4) @(posedge clk);
        chk(mute, 1);
        mute_n <= 1;
        repeat (4) @(posedge clk);
        chk(mute, 0);
        reg_mute <= 1;
        repeat (2) @(posedge clk);
        chk(mute, 1);
        reg_mute <= 0;
        $display("mute done");
    endtask
    task t_shunt;
        for (int s = 0; s < 8; s++) begin
            w(8'h04, 8'(s));
            chk(sh, s == 5);
        end
        $display("shunt done");
    endtask
    task test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) if (++cyc > 500) begin
        error_cnt++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        chk(vol, 6'h28);
        chk(fs[0], 6'h3f);
        chk(inf, 6'h0f);
        chk(sh, 6'h00);
        t_vol;
        t_fad;
        t_mute;
        t_shunt;
        test_done;
    end
endmodule // attenuation_code_decoder_tb_top
`default_nettype wire
